//--- core/flash_command_interface_epc.sv
// Purpose: command_decoder and erase_program_controller of the flash
// Assumes: array_rdata is the array word at bus_addr in the same cycle;
//          the array applies program and erase pulses itself
// Notes:   long erase counts are parameters so simulation can shorten
//
// Implementation choices: the plain strobed port and the placing of the registers.
module flash_command_interface_epc
    import flash_pkg::*;
#(
    parameter int ERASE_CYC = ERASE_MS * CLK_MHZ * 1000,
    parameter int CHIP_CYC = CHIP_MS * CLK_MHZ * 1000
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [flash_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_fetch_flash,
    output logic [31:0] bus_rdata_q,
    input wire logic [31:0] array_rdata,
    input wire logic array_fault,
    output logic array_prog_q,
    output logic [flash_pkg::ADDR_W-1:0] array_prog_addr_q,
    output logic [15:0] array_prog_data_q,
    output logic array_erase_q,
    output logic [flash_pkg::NUM_BLOCKS-1:0] array_erase_mask_q,
    input wire logic power_ok_pin,
    input wire logic external_access_select,
    input wire logic boot_mode_pin,
    output logic cpu_hold_reset_q,
    output logic ready_busy_q,
    output logic flash_irq_line_q
);
    import flash_pkg::*;

    // ==========================================================
    // helpers
    // one-hot erase block of a byte address, segment from bits 17:16
    function automatic logic [NUM_BLOCKS-1:0] blk_mask(
        input logic [ADDR_W-1:0] a);
        logic [NUM_BLOCKS-1:0] m;
        m = '0;
        unique case (a[17:16])
            2'h0: begin
                if (a[15:0] < BLK1_BASE) m = 7'h01;
                else if (a[15:0] < BLK2_BASE) m = 7'h02;
                else if (a[15:0] < BLK3_BASE) m = 7'h04;
                else m = 7'h08;
            end
            2'h1: m = 7'h10;
            2'h2: m = 7'h20;
            2'h3: m = 7'h40;
        endcase
        return m;
    endfunction : blk_mask

    // ==========================================================
    // state
    seq_e seq_q, seq_d; // command sequence position
    op_e op_q, op_d; // controller activity
    prot_e pkind_q; // which protect command is pending
    logic [NUM_BLOCKS-1:0] lock_q; // block locks, cleared only by reset
    logic [NUM_BLOCKS-1:0] tmp_unlock_q; // temporary block unlocks
    logic code_prot_q; // read protection installed
    logic code_tmp_q; // read protection lifted for update
    logic err_q; // failure flag
    logic tog6_q; // toggles per status read
    logic tog2_q; // toggles per erase status read
    logic tgt7_q; // bit 7 of the word being programmed
    logic busy_prev_q; // ready_busy one cycle back

    // synchronised pins
    logic pwr_ok_s, xsel_s, boot_s;

    sync_2ff #(.W(3)) pin_sync (
        .clk(clk),
        .reset(reset),
        .d({power_ok_pin, external_access_select, boot_mode_pin}),
        .q({pwr_ok_s, xsel_s, boot_s})
    );

    // ==========================================================
    // timers: main runs program/erase, aux runs the erase confirm
    // window and a program issued during suspend
    logic op_load, op_done, op_run;
    logic [CNT_W-1:0] op_count;
    logic aux_load, aux_done, aux_run;
    logic [CNT_W-1:0] aux_count;

    op_timer op_tmr (
        .clk(clk),
        .reset(reset),
        .load(op_load),
        .pause(op_q == OP_SUSP || op_q == OP_SPROG),
        .count(op_count),
        .done_q(op_done),
        .running_q(op_run)
    );

    op_timer aux_tmr (
        .clk(clk),
        .reset(reset),
        .load(aux_load),
        .pause(1'b0),
        .count(aux_count),
        .done_q(aux_done),
        .running_q(aux_run)
    );

    // ==========================================================
    // decode of the current bus cycle
    wire [7:0] cmd = bus_wdata[7:0];
    wire [NUM_BLOCKS-1:0] bmask = blk_mask(bus_addr);
    wire at_u1 = bus_addr == UNLOCK1_ADDR;
    wire at_u2 = bus_addr == UNLOCK2_ADDR;
    wire wr_u1 = bus_wr && at_u1 && cmd == CMD_UNLOCK1;
    wire wr_u2 = bus_wr && at_u2 && cmd == CMD_UNLOCK2;
    wire [NUM_BLOCKS-1:0] lock_eff = lock_q & ~tmp_unlock_q;
    wire blk_locked = |(bmask & lock_eff);
    wire rd_protected = code_prot_q && !code_tmp_q;
    // program, erase and suspended program all count as busy
    wire busy = op_q == OP_PROG || op_q == OP_ERASE || op_q == OP_SPROG;
    wire suspended = op_q == OP_SUSP;
    wire in_susp_blk = suspended && |(bmask & array_erase_mask_q);
    // old half word under the write, to catch a zero raised to one
    wire [15:0] old_half = bus_addr[1] ? array_rdata[31:16]
                                       : array_rdata[15:0];
    wire raise_one = |(bus_wdata & ~old_half);
    // a lone F0 from read state, or after both unlock writes
    wire reset_cmd = bus_wr && cmd == CMD_RESET &&
                     (seq_q == SQ_READ || seq_q == SQ_U2);
    wire idle_ready = op_q == OP_IDLE || suspended;

    // program data cycle: only when the controller may start it
    wire pdata_wr = seq_q == SQ_PDATA && bus_wr;
    wire prog_ok = pdata_wr && !blk_locked && !rd_protected &&
                   !raise_one && !in_susp_blk;
    wire prog_bad_bit = pdata_wr && raise_one;
    wire chip_wr = seq_q == SQ_E3 && bus_wr && at_u1 &&
                   cmd == CMD_CHIP_ERASE;
    wire confirm_wr = (seq_q == SQ_E3 || seq_q == SQ_EQ) && bus_wr &&
                      cmd == CMD_BLOCK_ERASE;
    wire queue_start = seq_q == SQ_EQ && aux_done &&
                       |array_erase_mask_q;
    wire suspend_wr = op_q == OP_ERASE && bus_wr &&
                      cmd == CMD_SUSPEND;
    wire resume_wr = suspended && seq_q == SQ_READ && bus_wr &&
                     cmd == CMD_RESUME;
    wire prot_wr = seq_q == SQ_PROT && bus_wr &&
                   cmd == CMD_PROT_CONFIRM;
    // temporary unprotect is refused while booting
    wire tmp_allowed = !boot_s;

    // show status instead of array data while anything runs
    wire show_status = busy || seq_q == SQ_EQ || in_susp_blk;
    wire poll_bit = (op_q == OP_PROG || op_q == OP_SPROG) ? ~tgt7_q
                  : suspended;
    wire [15:0] status_word = {8'h00, poll_bit, tog6_q, err_q, 1'b0,
                               seq_q != SQ_EQ, tog2_q, 2'b00};
    wire [31:0] rd_value = show_status ? {status_word, status_word}
        : (rd_protected && !bus_fetch_flash)
        ? {PROT_READ_VALUE, PROT_READ_VALUE}
        : array_rdata;

    // ==========================================================
    // timer requests
    assign op_load = prog_ok && op_q == OP_IDLE || queue_start ||
                     (chip_wr && idle_ready && |(~lock_eff));
    assign op_count = chip_wr ? CNT_W'(CHIP_CYC)
                    : queue_start ? CNT_W'(ERASE_CYC)
                    : CNT_W'(PROG_CYC);
    // every confirm write restarts the window
    assign aux_load = confirm_wr || (prog_ok && suspended);
    assign aux_count = confirm_wr ? CNT_W'(TMO_CYC) : CNT_W'(PROG_CYC);

    // ==========================================================
    // sequence next state; a mismatch always falls back to read
    always_comb begin
        seq_d = seq_q;
        if (seq_q == SQ_EQ && aux_done) begin
            seq_d = SQ_READ;
        end else if (bus_wr) begin
            unique case (seq_q)
                SQ_READ: begin
                    if (wr_u1 && idle_ready) seq_d = SQ_U1;
                end
                SQ_U1: seq_d = wr_u2 ? SQ_U2 : SQ_READ;
                SQ_U2: begin
                    seq_d = SQ_READ;
                    if (at_u1 && cmd == CMD_PROGRAM) seq_d = SQ_PDATA;
                    if (at_u1 && cmd == CMD_ERASE_SETUP && !suspended)
                        seq_d = SQ_E1;
                    if (at_u1 && (cmd == CMD_BLK_PROTECT ||
                        cmd == CMD_BLK_UNPROT || cmd == CMD_CODE_PROTECT ||
                        cmd == CMD_CODE_UNPROT) && !suspended)
                        seq_d = SQ_PROT;
                end
                SQ_E1: seq_d = wr_u1 ? SQ_E2 : SQ_READ;
                SQ_E2: seq_d = wr_u2 ? SQ_E3 : SQ_READ;
                SQ_E3: seq_d = confirm_wr ? SQ_EQ : SQ_READ;
                SQ_EQ: seq_d = confirm_wr ? SQ_EQ : SQ_READ;
                SQ_PDATA, SQ_PROT: seq_d = SQ_READ;
                default: seq_d = SQ_READ;
            endcase
        end
    end

    // ==========================================================
    // controller next state
    always_comb begin
        op_d = op_q;
        unique case (op_q)
            OP_IDLE: begin
                if (prog_ok || queue_start) op_d = queue_start
                    ? OP_ERASE : OP_PROG;
                if (chip_wr && |(~lock_eff)) op_d = OP_ERASE;
            end
            OP_PROG: if (op_done) op_d = OP_IDLE;
            OP_ERASE: begin
                if (op_done) op_d = OP_IDLE;
                else if (suspend_wr) op_d = OP_SUSP;
            end
            OP_SUSP: begin
                if (resume_wr) op_d = OP_ERASE;
                else if (prog_ok) op_d = OP_SPROG;
            end
            OP_SPROG: if (aux_done) op_d = OP_SUSP;
            default: op_d = OP_IDLE;
        endcase
    end

    // ==========================================================
    // state registers
    always_ff @(posedge clk) begin
        if (reset) begin
            seq_q <= SQ_READ;
            op_q <= OP_IDLE;
        end else begin
            seq_q <= seq_d;
            op_q <= op_d;
        end
    end

    // ==========================================================
    // protect command target, latched on the command write
    always_ff @(posedge clk) begin
        if (reset) begin
            pkind_q <= PK_BLK;
        end else if (seq_q == SQ_U2 && bus_wr) begin
            unique case (cmd)
                CMD_BLK_UNPROT: pkind_q <= PK_BLK_TMP;
                CMD_CODE_PROTECT: pkind_q <= PK_CODE;
                CMD_CODE_UNPROT: pkind_q <= PK_CODE_TMP;
                default: pkind_q <= PK_BLK;
            endcase
        end
    end

    // ==========================================================
    // protection bits; commands only ever set them, unlocks are temporary;
    // reset clears locks and unlocks alike
    always_ff @(posedge clk) begin
        if (reset) begin
            lock_q <= '0;
            tmp_unlock_q <= '0;
            code_prot_q <= 1'b0;
            code_tmp_q <= 1'b0;
        end else if (prot_wr) begin
            unique case (pkind_q)
                PK_BLK: lock_q <= lock_q | bmask;
                PK_BLK_TMP: if (tmp_allowed)
                    tmp_unlock_q <= tmp_unlock_q | bmask;
                PK_CODE: code_prot_q <= 1'b1;
                PK_CODE_TMP: if (tmp_allowed) code_tmp_q <= 1'b1;
            endcase
        end
    end

    // ==========================================================
    // erase queue: gathers unlocked blocks, dropped on abort
    always_ff @(posedge clk) begin
        if (reset) begin
            array_erase_mask_q <= '0;
        end else if (chip_wr && idle_ready) begin
            array_erase_mask_q <= ~lock_eff;
        end else if (confirm_wr && seq_q == SQ_E3) begin
            array_erase_mask_q <= bmask & ~lock_eff;
        end else if (confirm_wr) begin
            array_erase_mask_q <= array_erase_mask_q |
                                  (bmask & ~lock_eff);
        end else if (seq_q == SQ_EQ && seq_d == SQ_READ && !aux_done) begin
            array_erase_mask_q <= '0;
        end
    end

    // ==========================================================
    // program target latch
    always_ff @(posedge clk) begin
        if (reset) begin
            array_prog_addr_q <= '0;
            array_prog_data_q <= '0;
            tgt7_q <= 1'b0;
        end else if (prog_ok) begin
            array_prog_addr_q <= bus_addr;
            array_prog_data_q <= bus_wdata;
            tgt7_q <= bus_wdata[7];
        end
    end

    // ==========================================================
    // array pulses at the end of each operation
    always_ff @(posedge clk) begin
        if (reset) begin
            array_prog_q <= 1'b0;
            array_erase_q <= 1'b0;
        end else begin
            array_prog_q <= (op_q == OP_PROG && op_done) ||
                            (op_q == OP_SPROG && aux_done);
            array_erase_q <= op_q == OP_ERASE && op_done;
        end
    end

    // ==========================================================
    // status flags; a failure in the clearing cycle still sets
    wire err_set = prog_bad_bit ||
                   (array_fault && (op_done || aux_done) && busy);
    wire status_rd = bus_rd && show_status;
    always_ff @(posedge clk) begin
        if (reset) begin
            err_q <= 1'b0;
            tog6_q <= 1'b0;
            tog2_q <= 1'b0;
        end else begin
            err_q <= err_set || (err_q && !(reset_cmd && !busy));
            if (status_rd || suspend_wr || resume_wr)
                tog6_q <= !tog6_q;
            if (status_rd && (op_q == OP_ERASE || in_susp_blk))
                tog2_q <= !tog2_q;
        end
    end

    // ==========================================================
    // read data, valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            bus_rdata_q <= '0;
        end else if (bus_rd) begin
            bus_rdata_q <= rd_value;
        end
    end

    // ==========================================================
    // ready/busy, its interrupt edge and the cpu reset hold
    always_ff @(posedge clk) begin
        if (reset) begin
            ready_busy_q <= 1'b0;
            busy_prev_q <= 1'b0;
            flash_irq_line_q <= 1'b0;
            cpu_hold_reset_q <= 1'b0;
        end else begin
            ready_busy_q <= busy;
            busy_prev_q <= ready_busy_q;
            flash_irq_line_q <= busy_prev_q && !ready_busy_q;
            cpu_hold_reset_q <= xsel_s && !pwr_ok_s;
        end
    end

endmodule : flash_command_interface_epc

//--- core/flash_pkg.sv
// Purpose: shared constants for the flash command decoder and
//          erase_program_controller
// Assumes: 20 MHz clock, byte addresses on an 18-bit bus
// Notes:   command codes and protect confirm value are local choices
package flash_pkg;

    // ==========================================================
    // addressing
    localparam int ADDR_W = 18;
    localparam int NUM_BLOCKS = 7;
    localparam logic [17:0] UNLOCK1_ADDR = 18'h01554;
    localparam logic [17:0] UNLOCK2_ADDR = 18'h02AA8;
    // block boundaries inside segment 0
    localparam logic [15:0] BLK1_BASE = 16'h4000;
    localparam logic [15:0] BLK2_BASE = 16'h6000;
    localparam logic [15:0] BLK3_BASE = 16'h8000;

    // ==========================================================
    // command codes (low byte of the written word)
    localparam logic [7:0] CMD_UNLOCK1 = 8'hA8;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h54;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h30;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_BLK_PROTECT = 8'hC0;
    localparam logic [7:0] CMD_BLK_UNPROT = 8'hC1;
    localparam logic [7:0] CMD_CODE_PROTECT = 8'hC2;
    localparam logic [7:0] CMD_CODE_UNPROT = 8'hC3;
    localparam logic [7:0] CMD_PROT_CONFIRM = 8'h01;

    // ==========================================================
    // read answers
    localparam logic [15:0] PROT_READ_VALUE = 16'h009B;
    localparam int ST_POLL = 7;
    localparam int ST_TOG6 = 6;
    localparam int ST_ERR = 5;
    localparam int ST_TMO = 3;
    localparam int ST_TOG2 = 2;

    // ==========================================================
    // timing
    localparam int CLK_MHZ = 20;
    localparam int TMO_US = 96;
    localparam int TMO_CYC = TMO_US * CLK_MHZ;
    localparam int PROG_US = 16;
    localparam int PROG_CYC = PROG_US * CLK_MHZ;
    localparam int ERASE_MS = 1500;
    localparam int CHIP_MS = 8500;
    localparam int CNT_W = 28;

    // ==========================================================
    // state encodings, gray along the usual path
    typedef enum logic [3:0] {
        SQ_READ = 4'h0, SQ_U1 = 4'h1, SQ_U2 = 4'h3, SQ_PDATA = 4'h2,
        SQ_E1 = 4'h6, SQ_E2 = 4'h7, SQ_E3 = 4'h5, SQ_EQ = 4'h4,
        SQ_PROT = 4'hC
    } seq_e;
    typedef enum logic [2:0] {
        OP_IDLE = 3'h0, OP_PROG = 3'h1, OP_ERASE = 3'h3,
        OP_SUSP = 3'h2, OP_SPROG = 3'h6
    } op_e;
    typedef enum logic [1:0] {
        PK_BLK = 2'h0, PK_BLK_TMP = 2'h1, PK_CODE = 2'h3,
        PK_CODE_TMP = 2'h2
    } prot_e;

endpackage : flash_pkg

//--- core/op_timer.sv
// Purpose: pausable down counter for timeouts and operation length
// Assumes: count loaded is at least one
// Notes:   done is a one-cycle pulse when the count runs out
module op_timer
    import flash_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic pause,
    input wire logic [flash_pkg::CNT_W-1:0] count,
    output logic done_q,
    output logic running_q
);
    logic [CNT_W-1:0] cnt_q; // remaining cycles

    // ==========================================================
    // load wins over counting; pause freezes the remainder
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= '0;
            running_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (load) begin
                cnt_q <= count;
                running_q <= 1'b1;
            end else if (running_q && !pause) begin
                if (cnt_q <= 28'h0000001) begin
                    running_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 28'h0000001;
                end
            end
        end
    end
endmodule : op_timer

//--- core/sync_2ff.sv
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: inputs are slow levels, not pulses
// Notes:   only the second stage may be read by logic
module sync_2ff #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q; // first stage, read only by q

    // ==========================================================
    // two stages, cleared by reset
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : sync_2ff

//--- testbench/flash_array_model.sv
// Purpose: behavioural flash array behind the block
// Assumes: programming only clears bits, erase fills ones
// Notes:   untouched words hold a pattern made from their address
module flash_array_model (
    input wire logic clk,
    input wire logic [17:0] addr,
    input wire logic prog,
    input wire logic [17:0] prog_addr,
    input wire logic [15:0] prog_data,
    input wire logic erase,
    input wire logic [6:0] mask,
    output logic [31:0] rdata
);
    // ==========================================================
    logic [31:0] mem [int]; // only words that were programmed
    logic [6:0] erased = 7'h00; // blocks already filled with ones
    logic [31:0] w;
    int upd = 0; // bumps so the read path re-evaluates
    function automatic int blk(input logic [17:0] a);
        if (a[17:16] != 2'h0) return int'(a[17:16]) + 3;
        return a[15] ? 3 : (a[14] ? (a[13] ? 2 : 1) : 0);
    endfunction : blk
    function automatic logic [31:0] word(input logic [17:0] a, int u);
        if (mem.exists(a[17:2])) return mem[a[17:2]];
        return erased[blk(a)] ? 32'hFFFFFFFF : {a[17:2], ~a[17:2]};
    endfunction : word
    assign rdata = word(addr, upd);
    // a program pulse can only pull bits of one half low
    always @(posedge clk) begin
        w = word(prog_addr, upd);
        if (prog) begin
            w = w & (prog_addr[1] ? {prog_data, 16'hFFFF}
                                  : {16'hFFFF, prog_data});
            mem[prog_addr[17:2]] = w;
        end
        if (erase) begin
            foreach (mem[k])
                if (mask[blk({k[15:0], 2'b00})]) mem[k] = 32'hFFFFFFFF;
            erased = erased | mask;
        end
        upd++;
    end
endmodule : flash_array_model

//--- testbench/flash_cmd_asserts.sv
// Purpose: port checks for the flash command block
// Assumes: one clock, synchronous active high reset
// Notes:   latencies follow the designer's hand-over figures
module flash_cmd_checks (
    input wire logic clk,
    input wire logic reset,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata_q,
    input wire logic array_prog_q,
    input wire logic array_erase_q,
    input wire logic power_ok_pin,
    input wire logic external_access_select,
    input wire logic cpu_hold_reset_q,
    input wire logic ready_busy_q,
    input wire logic flash_irq_line_q
);
    // ==========================================================
    // properties, all in the one clock domain
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    irq_after_ready_a: assert property ($fell(ready_busy_q) |-> ##1
        flash_irq_line_q) else $error("no irq after ready");
    irq_one_pulse_a: assert property (flash_irq_line_q |=>
        !flash_irq_line_q) else $error("irq longer than a cycle");
    prog_ends_busy_a: assert property (array_prog_q |=>
        !ready_busy_q) else $error("busy after program end");
    prog_while_busy_a: assert property (array_prog_q |->
        ready_busy_q) else $error("program pulse while ready");
    erase_while_busy_a: assert property (array_erase_q |-> ##[0:1]
        ready_busy_q) else $error("erase pulse while ready");
    rdata_holds_a: assert property (!$past(bus_rd) |->
        $stable(bus_rdata_q)) else $error("read data moved");
    // status answers have an empty top byte and equal halves
    status_read_a: assert property (bus_rd && ready_busy_q
        && !array_prog_q && !array_erase_q |=> bus_rdata_q[15:8] == 8'h00
        && bus_rdata_q[31:16] == bus_rdata_q[15:0])
        else $error("status read malformed");
    cpu_hold_a: assert property ((external_access_select
        && !power_ok_pin)[*5] |-> cpu_hold_reset_q)
        else $error("cpu not held");
    cpu_free_a: assert property (power_ok_pin[*4] |->
        !cpu_hold_reset_q) else $error("cpu held after power ok");
endmodule : flash_cmd_checks

bind flash_command_interface_epc flash_cmd_checks i_chk (.clk, .reset,
    .bus_rd, .bus_rdata_q, .array_prog_q, .array_erase_q, .power_ok_pin,
    .external_access_select, .cpu_hold_reset_q, .ready_busy_q,
    .flash_irq_line_q);

//--- testbench/test_flash_command_interface_epc.sv
// Purpose: self-checking bench for the flash command block
// Assumes: 20 MHz clock, block erase shortened to 50 cycles, chip erase to 80
// Notes:   every read is checked the cycle after its strobe
module test_flash_command_interface_epc;
    timeunit 1ns;
    timeprecision 1ns;
    import flash_pkg::*;
    // ==========================================================
    logic clk = 0, reset = 1, wr = 0, rd = 0, ff = 0, rd_d = 0;
    logic pok = 0, xsel = 1;
    logic [17:0] a = 18'h00000, pa;
    logic [15:0] wd = 16'h0000, pd;
    logic [31:0] ar, rq, t, seed = 32'h8FF6E37F, qe[$], qm[$];
    logic [6:0] em;
    logic pg, er, rb;
    int err_count = 0, comparisons = 0;
    localparam logic [31:0] F = 32'hFFFFFFFF;
    always #25 clk = ~clk;
    flash_command_interface_epc #(.ERASE_CYC(50), .CHIP_CYC(80)) i_dut (
        .clk(clk), .reset(reset), .bus_addr(a), .bus_wdata(wd),
        .bus_wr(wr), .bus_rd(rd), .bus_fetch_flash(ff), .bus_rdata_q(rq),
        .array_rdata(ar), .array_fault(1'b0), .array_prog_q(pg),
        .array_prog_addr_q(pa), .array_prog_data_q(pd), .array_erase_q(er),
        .array_erase_mask_q(em), .power_ok_pin(pok),
        .external_access_select(xsel), .boot_mode_pin(1'b0),
        .cpu_hold_reset_q(), .ready_busy_q(rb), .flash_irq_line_q());
    flash_array_model i_arr (.clk(clk), .addr(a), .prog(pg),
        .prog_addr(pa), .prog_data(pd), .erase(er), .mask(em), .rdata(ar));
    function automatic logic [31:0] pat(input logic [17:0] x);
        return {x[17:2], ~x[17:2]};
    endfunction : pat
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_t(input logic [17:0] ad, input logic [15:0] d);
        @(posedge clk);
        a <= ad;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_t
    // the expected word is queued as the read is issued
    task automatic rd_t(input logic [17:0] ad, input logic [31:0] e,
                        input logic [31:0] m);
        @(posedge clk);
        a <= ad;
        rd <= 1'b1;
        qe.push_back(e & m);
        qm.push_back(m);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_t
    task automatic cmd(input logic [7:0] c);
        wr_t(UNLOCK1_ADDR, {8'h00, CMD_UNLOCK1});
        wr_t(UNLOCK2_ADDR, {8'h00, CMD_UNLOCK2});
        wr_t(UNLOCK1_ADDR, {8'h00, c});
    endtask : cmd
    // bounded wait on the busy line, a miss counts as a mismatch
    task automatic wait_rb(input logic v);
        int n;
        n = 0;
        while (rb !== v && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, rb}, {31'h0, v});
    endtask : wait_rb
    task automatic give_verdict();
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // result watcher: oldest queued note against the read data
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) check(rq & qm.pop_front(), qe.pop_front());
    end
    initial begin
        #1000000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        pok <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            t = seed;
            t ^= t << 13;
            t ^= t >> 17;
            seed = t ^ (t << 5);
            rd_t(seed[17:0], pat(seed[17:0]), F);
        end
        cmd(CMD_PROGRAM);
        rd_t(18'h00106, pat(18'h00106), F);
        wr_t(18'h00106, 16'h0000);
        wait_rb(1'b1);
        rd_t(18'h00106, 32'h00880088, 32'hFFBFFFBF);
        wait_rb(1'b0);
        rd_t(18'h00104, pat(18'h00104) & 32'h0000FFFF, F);
        cmd(8'h00);
        wr_t(18'h00200, 16'h0000);
        rd_t(18'h00200, pat(18'h00200), F);
        cmd(CMD_RESET);
        cmd(CMD_BLK_PROTECT);
        wr_t(18'h04000, {8'h00, CMD_PROT_CONFIRM});
        wait_rb(1'b0);
        cmd(CMD_PROGRAM);
        wr_t(18'h04000, 16'h0000);
        rd_t(18'h04000, pat(18'h04000), F);
        cmd(CMD_ERASE_SETUP);
        cmd(CMD_BLOCK_ERASE);
        wr_t(18'h04000, {8'h00, CMD_BLOCK_ERASE});
        wr_t(18'h20000, {8'h00, CMD_BLOCK_ERASE});
        wait_rb(1'b1);
        wait_rb(1'b0);
        rd_t(18'h00104, F, F);
        rd_t(18'h20000, F, F);
        rd_t(18'h04000, pat(18'h04000), F);
        cmd(CMD_ERASE_SETUP);
        wr_t(UNLOCK1_ADDR, {8'h00, CMD_UNLOCK1});
        wr_t(UNLOCK2_ADDR, {8'h00, CMD_UNLOCK2});
        wr_t(18'h30000, {8'h00, CMD_BLOCK_ERASE});
        wait_rb(1'b1);
        wr_t(18'h00000, {8'h00, CMD_SUSPEND});
        wait_rb(1'b0);
        rd_t(18'h10000, pat(18'h10000), F);
        wr_t(18'h00000, {8'h00, CMD_RESUME});
        wait_rb(1'b1);
        wait_rb(1'b0);
        rd_t(18'h30000, F, F);
        cmd(CMD_ERASE_SETUP);
        cmd(CMD_CHIP_ERASE);
        wait_rb(1'b1);
        wait_rb(1'b0);
        rd_t(18'h10000, F, F);
        cmd(CMD_CODE_PROTECT);
        wr_t(18'h00000, {8'h00, CMD_PROT_CONFIRM});
        wait_rb(1'b0);
        rd_t(18'h00300, {2{PROT_READ_VALUE}}, F);
        ff <= 1'b1;
        rd_t(18'h00300, F, F);
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule : test_flash_command_interface_epc
